// [inc/imc_pkg.sv]
// Constants, register map and carrier types for the insulation monitor control block.
// Assumes a 10 MHz system clock and a register port driven by a serial protocol front end.
package imc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_POS_RES = 16'h0012;
    localparam logic [15:0] ADDR_NEG_RES = 16'h0013;
    localparam logic [15:0] ADDR_STATUS = 16'h0014;
    localparam logic [15:0] ADDR_POS_VOLT = 16'h0015;
    localparam logic [15:0] ADDR_NEG_VOLT = 16'h0016;
    localparam logic [15:0] ADDR_MODE = 16'h0100;
    localparam logic [15:0] ADDR_ENABLE = 16'h0102;
    localparam logic [15:0] MODE_AUTO = 16'h0004;
    localparam logic [15:0] MODE_FIXED = 16'h0000;
    localparam logic [15:0] ENABLE_ON = 16'h0001;
    localparam logic [15:0] ENABLE_OFF = 16'h0000;
    localparam logic [15:0] CODE_INVALID = 16'hFFFF;
    localparam logic [15:0] CODE_INFINITY = 16'hEA60;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;
    // Status field positions
    localparam int ST_RES_VALID = 1;
    localparam int ST_MON_ON = 2;
    localparam int ST_SELFTEST = 4;
    localparam int ST_MODE_LO = 8;
    localparam logic [2:0] STMODE_AUTO = 3'h4;
    localparam logic [2:0] STMODE_FIXED = 3'h0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_HZ = 1000;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    localparam int SELFTEST_PERIOD_MS = 5000;
    localparam int SETTLE_MIN_MS = 700;
    localparam int SETTLE_MAX_MS = 2000;
    localparam int LED_PERIOD_MS = 2000;
    localparam int LED_LONG_MS = 1500;
    localparam int LED_SHORT_MS = 500;
    localparam int SELFTEST_ACTIVE_MS = LED_PERIOD_MS;
    // ------------------------------------------------------------
    // DIP decoding
    // ------------------------------------------------------------
    localparam int DIP_BAUD = 0;
    localparam int DIP_ADDR_LO = 1;
    localparam int DIP_PAR_LO = 4;
    typedef enum logic [1:0] {
        IMC_PAR_NONE = 2'b00,
        IMC_PAR_ODD = 2'b01,
        IMC_PAR_EVEN = 2'b10,
        IMC_PAR_BAD = 2'b11
    } imc_parity_t;
    typedef struct packed {
        logic baud_19200;
        logic [7:0] slave_addr;
        imc_parity_t parity;
    } imc_comm_cfg_t;
    // Register access request from the protocol front end
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } imc_reg_req_t;
    // Analog front end results
    typedef struct packed {
        logic bus_ge_100v;
        logic res_ready;
        logic [15:0] pos_res;
        logic [15:0] neg_res;
        logic pos_over_10m;
        logic neg_over_10m;
        logic [15:0] pos_volt;
        logic [15:0] neg_volt;
        logic [15:0] bridge_sample;
        logic [15:0] bridge_expect;
        logic bridge_sample_vld;
    } imc_meas_t;
endpackage : imc_pkg

// [design/imc_top.sv]
// Insulation monitor status and control: registers, validity gating, self-test, LED, DIP.
// Assumes synchronous inputs, a Modbus front end issuing one-cycle rd/wr pulses.
`timescale 1ns/10ps
`default_nettype none
module imc_top #(
    parameter int SELFTEST_CNT = imc_pkg::SELFTEST_PERIOD_MS,
    parameter int TICK_DIV = imc_pkg::TICK_DIV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire imc_pkg::imc_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire imc_pkg::imc_meas_t meas,
    input wire logic [5:0] dip_sw,
    output imc_pkg::imc_comm_cfg_t comm_cfg,
    output logic ground_switch,
    output logic power_indicator,
    output logic monitoring_led,
    output logic selftest_active,
    output logic bus_monitor_on
);
    import imc_pkg::*;

    // ------------------------------------------------------------
    // Free-running tick
    // ------------------------------------------------------------
    logic [15:0] div_ff;
    logic tick_ff;
    // One pulse per millisecond shared by all timers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else if (div_ff == 16'(TICK_DIV - 1)) begin
            div_ff <= 16'h0000;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 16'h0001;
            tick_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic mon_on_ff;
    logic mode_auto_ff;
    logic wr_mode;
    logic wr_en;
    assign wr_mode = reg_req.wr && (reg_req.addr == ADDR_MODE);
    assign wr_en = reg_req.wr && (reg_req.addr == ADDR_ENABLE);
    // Enable write; any nonzero value turns monitoring on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_on_ff <= 1'b0;
        end else if (wr_en) begin
            mon_on_ff <= (reg_req.wdata != ENABLE_OFF);
        end
    end
    // Mode write; enable writes never touch it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_auto_ff <= 1'b1;
        end else if (wr_mode) begin
            if (reg_req.wdata == MODE_AUTO) begin
                mode_auto_ff <= 1'b1;
            end else if (reg_req.wdata == MODE_FIXED) begin
                mode_auto_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Settling window after enable
    // ------------------------------------------------------------
    logic [15:0] settle_ff;
    logic settled_ff;
    // Count ms since enable; settled at the minimum once a result is ready, at the maximum without one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_ff <= 16'h0000;
            settled_ff <= 1'b0;
        end else if (!mon_on_ff) begin
            settle_ff <= 16'h0000;
            settled_ff <= 1'b0;
        end else if (tick_ff && !settled_ff) begin
            settle_ff <= settle_ff + 16'h0001;
            if (settle_ff >= 16'(SETTLE_MIN_MS - 1) && meas.res_ready) begin
                settled_ff <= 1'b1;
            end else if (settle_ff >= 16'(SETTLE_MAX_MS - 1)) begin
                settled_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Self-test scheduler
    // ------------------------------------------------------------
    logic [15:0] st_cnt_ff;
    logic [15:0] st_act_ff;
    logic st_busy_ff;
    logic st_pass_ff;
    logic st_arm;
    assign st_arm = meas.bus_ge_100v && !mon_on_ff;
    // Period timer; restarts whenever conditions drop so no stale test fires
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_cnt_ff <= 16'h0000;
        end else if (!st_arm) begin
            st_cnt_ff <= 16'h0000;
        end else if (tick_ff) begin
            if (st_cnt_ff == 16'(SELFTEST_CNT - 1)) begin
                st_cnt_ff <= 16'h0000;
            end else begin
                st_cnt_ff <= st_cnt_ff + 16'h0001;
            end
        end
    end
    // Active window, long enough for one LED cycle
    // A period shorter than the window must not restart a running test forever
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_busy_ff <= 1'b0;
            st_act_ff <= 16'h0000;
        end else if (st_arm && !st_busy_ff && tick_ff
                     && st_cnt_ff == 16'(SELFTEST_CNT - 1)) begin
            st_busy_ff <= 1'b1;
            st_act_ff <= 16'h0000;
        end else if (st_busy_ff && tick_ff) begin
            if (st_act_ff == 16'(SELFTEST_ACTIVE_MS - 1)) begin
                st_busy_ff <= 1'b0;
            end
            st_act_ff <= st_act_ff + 16'h0001;
        end
    end
    // Judge on each bridge sample during the test; otherwise keep old result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_pass_ff <= 1'b0;
        end else if (st_busy_ff && meas.bridge_sample_vld) begin
            st_pass_ff <= (meas.bridge_sample == meas.bridge_expect);
        end
    end

    // ------------------------------------------------------------
    // Result gating
    // ------------------------------------------------------------
    logic res_valid;
    logic volt_valid;
    assign res_valid = mon_on_ff && settled_ff && meas.bus_ge_100v && mode_auto_ff;
    assign volt_valid = mon_on_ff && !mode_auto_ff;

    // Resistance code selection: invalid, infinity or measured
    function automatic logic [15:0] res_code(input logic vld, input logic over,
                                             input logic [15:0] val);
        if (!vld) begin
            res_code = CODE_INVALID;
        end else if (over) begin
            res_code = CODE_INFINITY;
        end else begin
            res_code = val;
        end
    endfunction : res_code

    logic [15:0] status;
    // Status word built from live state
    always_comb begin
        status = 16'h0000;
        status[ST_RES_VALID] = res_valid;
        status[ST_MON_ON] = mon_on_ff;
        status[ST_SELFTEST] = st_pass_ff;
        status[ST_MODE_LO +: 3] = mode_auto_ff ? STMODE_AUTO : STMODE_FIXED;
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    logic [15:0] nxt_rdata;
    // Read mux; unmapped addresses read zero
    always_comb begin
        nxt_rdata = UNMAPPED_READ;
        unique case (reg_req.addr)
            ADDR_POS_RES: nxt_rdata = res_code(res_valid, meas.pos_over_10m, meas.pos_res);
            ADDR_NEG_RES: nxt_rdata = res_code(res_valid, meas.neg_over_10m, meas.neg_res);
            ADDR_STATUS: nxt_rdata = status;
            ADDR_POS_VOLT: nxt_rdata = volt_valid ? meas.pos_volt : CODE_INVALID;
            ADDR_NEG_VOLT: nxt_rdata = volt_valid ? meas.neg_volt : CODE_INVALID;
            ADDR_MODE: nxt_rdata = mode_auto_ff ? MODE_AUTO : MODE_FIXED;
            ADDR_ENABLE: nxt_rdata = mon_on_ff ? ENABLE_ON : ENABLE_OFF;
            default: nxt_rdata = UNMAPPED_READ;
        endcase
    end
    // Registered read answer one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata <= nxt_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // LED pattern
    // ------------------------------------------------------------
    logic [15:0] led_ph_ff;
    // Phase within the 2 s blink period, from the shared tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_ph_ff <= 16'h0000;
        end else if (!st_busy_ff) begin
            led_ph_ff <= 16'h0000;
        end else if (tick_ff) begin
            if (led_ph_ff == 16'(LED_PERIOD_MS - 1)) begin
                led_ph_ff <= 16'h0000;
            end else begin
                led_ph_ff <= led_ph_ff + 16'h0001;
            end
        end
    end
    logic nxt_led;
    // Four-way pattern choice
    always_comb begin
        unique case ({mon_on_ff, st_busy_ff})
            2'b10: nxt_led = 1'b1;
            2'b11: nxt_led = (led_ph_ff < 16'(LED_LONG_MS));
            2'b01: nxt_led = (led_ph_ff < 16'(LED_SHORT_MS));
            2'b00: nxt_led = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Pin outputs and DIP decode
    // ------------------------------------------------------------
    imc_comm_cfg_t nxt_cfg;
    // ON reads as 1 straight from the switch level
    always_comb begin
        nxt_cfg.baud_19200 = dip_sw[DIP_BAUD];
        nxt_cfg.slave_addr = {5'h00, dip_sw[DIP_ADDR_LO +: 3]};
        nxt_cfg.parity = imc_parity_t'(dip_sw[DIP_PAR_LO +: 2]);
    end
    // All pins registered so no decode glitches reach the relay or LED
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ground_switch <= 1'b0;
            power_indicator <= 1'b0;
            monitoring_led <= 1'b0;
            selftest_active <= 1'b0;
            bus_monitor_on <= 1'b0;
            comm_cfg <= '0;
        end else begin
            ground_switch <= mon_on_ff;
            power_indicator <= 1'b1;
            bus_monitor_on <= 1'b1;
            monitoring_led <= nxt_led;
            selftest_active <= st_busy_ff;
            comm_cfg <= nxt_cfg;
        end
    end
endmodule : imc_top
`default_nettype wire

// [tb/imc_props.sv]
// Assertion checker for the insulation monitor control block.
// Sees only imc_top ports; bound to every imc_top at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module imc_props #(
    parameter int SELFTEST_CNT = 20,
    parameter int TICK_DIV = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire imc_pkg::imc_reg_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire imc_pkg::imc_meas_t meas,
    input wire logic [5:0] dip_sw,
    input wire imc_pkg::imc_comm_cfg_t comm_cfg,
    input wire logic ground_switch,
    input wire logic power_indicator,
    input wire logic monitoring_led,
    input wire logic selftest_active,
    input wire logic bus_monitor_on
);
    import imc_pkg::*;
    // ------------------------------------------------------------
    // Properties, one clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Register port answers once per read, never unprompted
    rd_answer_a: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read got no answer");
    rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_req.rd))
        else $error("answer without read");
    // Switch follows the enable write two edges later
    gnd_close_a: assert property (reg_req.wr && reg_req.addr == ADDR_ENABLE
        && reg_req.wdata != 16'h0000 |-> ##2 ground_switch) else $error("switch not closed");
    gnd_open_a: assert property (reg_req.wr && reg_req.addr == ADDR_ENABLE
        && reg_req.wdata == 16'h0000 |-> ##2 !ground_switch) else $error("switch not opened");
    // First edge after release is vacuous: outputs still leave reset there
    power_lit_a: assert property ($past(rst_n) |-> power_indicator && bus_monitor_on)
        else $error("power indicator dark");
    dip_decode_a: assert property ($past(rst_n) |-> comm_cfg ==
        {$past(dip_sw[0]), 5'h00, $past(dip_sw[3:1]), $past(dip_sw[5:4])})
        else $error("switch decode wrong");
    // Three cycles of a steady state absorb the register lag of the lamp
    led_dark_a: assert property ((!ground_switch && !selftest_active)[*3]
        |-> !monitoring_led) else $error("lamp lit while idle");
    led_steady_a: assert property ((ground_switch && !selftest_active)[*3]
        |-> monitoring_led) else $error("lamp not steady");
    res_invalid_a: assert property (reg_rvalid && $past(reg_req.addr) == ADDR_POS_RES
        && !$past(ground_switch) |-> reg_rdata == CODE_INVALID) else $error("bad resistance");
    // Start was decided one edge before the lamp copy; an enable in that edge is legal
    test_off_a: assert property ($rose(selftest_active) |-> !$past(ground_switch))
        else $error("self-test while enabled");
    // Main scenarios reached
    cover property ($rose(selftest_active));
    cover property (reg_rvalid && reg_rdata == CODE_INFINITY);
    cover property (selftest_active && $fell(monitoring_led));
endmodule : imc_props
bind imc_top imc_props #(.SELFTEST_CNT(SELFTEST_CNT), .TICK_DIV(TICK_DIV)) imc_props_inst (
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .meas(meas), .dip_sw(dip_sw), .comm_cfg(comm_cfg),
    .ground_switch(ground_switch), .power_indicator(power_indicator),
    .monitoring_led(monitoring_led), .selftest_active(selftest_active),
    .bus_monitor_on(bus_monitor_on));
`default_nettype wire

// [tb/imc_host_model.sv]
// Host side of the register port: one-cycle read and write requests.
// Waits up to four cycles after the read request edge for the answer.
`timescale 1ns/10ps
`default_nettype none
module imc_host_model (
    input wire logic clk,
    output var imc_pkg::imc_reg_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    import imc_pkg::*;
    // Idle bus shows inverted last address; data is inverted after a write, copied from the request after a read
    initial reg_req = '0;
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_req <= '{1'b0, 1'b1, a, d};
        @(posedge clk);
        reg_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    // Data stays unknown on a missing answer so the compare fails
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        int n;
        d = 'x;
        @(posedge clk);
        reg_req <= '{1'b1, 1'b0, a, ~reg_req.wdata};
        @(posedge clk);
        reg_req <= '{1'b0, 1'b0, ~a, reg_req.wdata};
        for (n = 0; n < 4; n++) begin
            @(posedge clk);
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                break;
            end
        end
    endtask : rd
endmodule : imc_host_model
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the insulation monitor control block.
// Assumes shortened timing: 10 clocks a tick, 20-tick self-test period.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import imc_pkg::*;
    localparam logic [15:0] INV_REGS [4] = '{ADDR_POS_RES, ADDR_NEG_RES, ADDR_POS_VOLT,
        ADDR_NEG_VOLT};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    imc_reg_req_t reg_req;
    logic [15:0] reg_rdata, v;
    logic reg_rvalid, ground_switch, power_indicator, monitoring_led, selftest_active;
    logic bus_monitor_on;
    imc_meas_t meas = '{1'b1, 1'b0, 16'h1234, 16'h0567, 1'b0, 1'b0, 16'h0111, 16'h0222,
        16'h0ABC, 16'h0ABC, 1'b0};
    logic [5:0] dip_sw = 6'b10_101_1;
    imc_comm_cfg_t comm_cfg;
    int err_count = 0;
    int samples_checked = 0;
    int n;
    // 10 MHz clock
    always #50 clk = ~clk;
    imc_top #(.SELFTEST_CNT(20), .TICK_DIV(10)) imc_top_inst (.clk(clk), .rst_n(rst_n),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .meas(meas),
        .dip_sw(dip_sw), .comm_cfg(comm_cfg), .ground_switch(ground_switch),
        .power_indicator(power_indicator), .monitoring_led(monitoring_led),
        .selftest_active(selftest_active), .bus_monitor_on(bus_monitor_on));
    imc_host_model imc_host_model_inst (.clk(clk), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_of_test;
        if (err_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Masked register read and compare
    task automatic rchk(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
        imc_host_model_inst.rd(a, v);
        chk(v & m, e);
    endtask : rchk
    // Bounded wait on the self-test window; a hang ends the run
    task automatic wait_sel(input logic lvl);
        for (n = 0; n < 30000 && selftest_active !== lvl; n++) @(posedge clk);
        if (selftest_active !== lvl) begin
            err_count++;
            end_of_test();
        end
    endtask : wait_sel
    task automatic pulse_vld;
        meas.bridge_sample_vld <= 1'b1;
        @(posedge clk);
        meas.bridge_sample_vld <= 1'b0;
    endtask : pulse_vld
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(16'(power_indicator), 16'h0001);
        chk(16'(comm_cfg), 16'b1_00000101_10);
        for (int p = 0; p < 3; p++) begin
            dip_sw <= {p[1:0], 3'b111, 1'b0};
            repeat (2) @(posedge clk);
            chk(16'(comm_cfg), {8'h00, 6'h07, p[1:0]});
        end
        rchk(ADDR_MODE, 16'hFFFF, MODE_AUTO);
        rchk(ADDR_STATUS, 16'h0716, 16'h0400);
        imc_host_model_inst.wr(ADDR_POS_RES, 16'h0000);
        foreach (INV_REGS[i]) rchk(INV_REGS[i], 16'hFFFF, CODE_INVALID);
        rchk(16'h0050, 16'hFFFF, UNMAPPED_READ);
        // Self-test: pass, lamp duty, hold, then fail
        wait_sel(1'b1);
        pulse_vld();
        n = 0;
        repeat (20000) begin
            @(posedge clk);
            n += int'(monitoring_led === 1'b1);
        end
        chk(16'(n > 4980 && n < 5020), 16'h0001);
        wait_sel(1'b0);
        rchk(ADDR_STATUS, 16'h0010, 16'h0010);
        wait_sel(1'b1);
        meas.bridge_sample <= 16'h0ABD;
        pulse_vld();
        rchk(ADDR_STATUS, 16'h0010, 16'h0000);
        wait_sel(1'b0);
        // Enable with no front-end result: only the 2 s limit validates
        imc_host_model_inst.wr(ADDR_ENABLE, 16'h0001);
        repeat (3) @(posedge clk);
        chk(16'(ground_switch), 16'h0001);
        rchk(ADDR_ENABLE, 16'hFFFF, ENABLE_ON);
        rchk(ADDR_STATUS, 16'h0006, 16'h0004);
        repeat (7500) @(posedge clk);
        rchk(ADDR_POS_RES, 16'hFFFF, CODE_INVALID);
        repeat (13000) @(posedge clk);
        rchk(ADDR_POS_RES, 16'hFFFF, 16'h1234);
        rchk(ADDR_NEG_RES, 16'hFFFF, 16'h0567);
        rchk(ADDR_STATUS, 16'h0706, 16'h0406);
        meas.res_ready <= 1'b1;
        meas.pos_over_10m <= 1'b1;
        repeat (2) @(posedge clk);
        rchk(ADDR_POS_RES, 16'hFFFF, CODE_INFINITY);
        meas.bus_ge_100v <= 1'b0;
        repeat (2) @(posedge clk);
        rchk(ADDR_POS_RES, 16'hFFFF, CODE_INVALID);
        rchk(ADDR_STATUS, 16'h0002, 16'h0000);
        meas.bus_ge_100v <= 1'b1;
        imc_host_model_inst.wr(ADDR_MODE, MODE_FIXED);
        rchk(ADDR_POS_VOLT, 16'hFFFF, 16'h0111);
        rchk(ADDR_NEG_VOLT, 16'hFFFF, 16'h0222);
        rchk(ADDR_STATUS, 16'h0702, 16'h0000);
        imc_host_model_inst.wr(ADDR_MODE, 16'h0007);
        rchk(ADDR_MODE, 16'hFFFF, MODE_FIXED);
        imc_host_model_inst.wr(ADDR_ENABLE, ENABLE_OFF);
        repeat (3) @(posedge clk);
        chk(16'(ground_switch), 16'h0000);
        rchk(ADDR_MODE, 16'hFFFF, MODE_FIXED);
        rchk(ADDR_POS_VOLT, 16'hFFFF, CODE_INVALID);
        rchk(ADDR_STATUS, 16'h0004, 16'h0000);
        // Low bus keeps the self-test from starting
        wait_sel(1'b0);
        meas.bus_ge_100v <= 1'b0;
        n = 0;
        repeat (1000) begin
            @(posedge clk);
            n += int'(selftest_active !== 1'b0);
        end
        chk(16'(n), 16'h0000);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
